// *** flash_dev_model.sv ***
// Purpose: Behavioural flash status model.
// Assumes: Busy span counted in status reads.
// Notes: Clockless; driven by strobes.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model (
   // Host pins
   input wire flash_status_pkg::strobes_s strobes,
   input wire logic [15:0] dq_out,
   output logic [15:0] dq_in,
   output logic rdy,
   // Scenario controls
   input wire logic load,
   input wire logic [1:0] op,
   input wire logic [31:0] n,
   input wire logic to,
   input wire logic [15:0] pd
);
   logic [31:0] left = '0;
   logic t1 = 1'b0;
   logic t2 = 1'b0;
   logic tf = 1'b0;
   logic [15:0] rd = '0;
   assign rdy = (left != 0 && op != 2'd3) ? 1'b0 : 1'b1;
   // Released bus shows inverse, never a held value
   assign dq_in = (!strobes.ce_n && !strobes.oe_n) ? rd : ~rd;
   always @(negedge strobes.oe_n or posedge strobes.we_n or posedge load) begin
      if (load) begin
         left = n;
         t1 = 1'b0;
         t2 = 1'b0;
         tf = to;
      end else if (!strobes.oe_n) begin
         if (left == 0) begin
            rd = pd;
         end else begin
            t1 = (op == 2'd3) ? t1 : ~t1;
            t2 = (op == 2'd1) ? t2 : ~t2;
            rd = {8'h00, (op == 2'd1) ? ~pd[7] : (op == 2'd3), t1, tf, 2'b00, t2, 2'b00};
            left = tf ? left : left - 1;
         end
      end else if (dq_out[7:0] == flash_status_pkg::reset_cmd) begin
         left = '0;
         tf = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** flash_status_chk.sv ***
// Purpose: Port checks for the flash status poller.
// Assumes: One clock, async active-low reset.
// Notes: Bound to the poller.
`timescale 1ns/10ps
`default_nettype none
module flash_status_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // User side
   input wire logic start,
   input wire logic issue_reset,
   input wire logic [17:0] poll_addr,
   input wire logic busy,
   input wire logic done,
   // Flash side
   input wire logic [17:0] flash_addr,
   input wire flash_status_pkg::strobes_s flash_strobes,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence read_cycle;
      !flash_strobes.oe_n [*3] ##1 flash_strobes.oe_n;
   endsequence
   sequence reset_write;
      ##[1:8] (!flash_strobes.we_n && flash_dq_oe && flash_addr == '0 &&
         flash_dq_out[7:0] == flash_status_pkg::reset_cmd);
   endsequence
   AST_READ_LEN: assert property ($fell(flash_strobes.oe_n) |-> read_cycle)
      else $error("read cycle length wrong");
   AST_RESET_WR: assert property (issue_reset && !busy |-> reset_write)
      else $error("reset command not written");
   AST_START_BUSY: assert property ((start || issue_reset) && !busy |=> busy)
      else $error("request not taken");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done longer than one cycle");
   AST_NO_CLASH: assert property (flash_dq_oe |-> flash_strobes.oe_n)
      else $error("driving data during a read");
   AST_ADDR_HOLD: assert property (!flash_strobes.oe_n && !$past(flash_strobes.oe_n)
      |-> $stable(flash_addr))
      else $error("address moved in a read");
   AST_POLL_ADDR: assert property (busy && !flash_strobes.oe_n |-> flash_addr == poll_addr)
      else $error("status read at wrong address");
   AST_CE_READ: assert property (!flash_strobes.oe_n |-> !flash_strobes.ce_n)
      else $error("read without chip select");
endmodule
bind flash_status_poller flash_status_chk u_flash_status_chk (.clk(clk), .resetn(resetn),
   .start(start), .issue_reset(issue_reset), .poll_addr(poll_addr), .busy(busy), .done(done),
   .flash_addr(flash_addr), .flash_strobes(flash_strobes), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// *** flash_status_pkg.sv ***
// Purpose: Constants and carrier types for the flash status poller.
// Assumes: 20 MHz clock, bus cycles timed in whole clock cycles.
package flash_status_pkg;
   localparam int data_w = 16;
   localparam int addr_w = 18;
   localparam logic [3:0] bus_cycles = 4'h4;
   localparam logic [7:0] reset_cmd = 8'hf0;
   localparam int poll_bit = 7;
   localparam int toggle1_bit = 6;
   localparam int timeout_bit = 5;
   localparam int toggle2_bit = 2;
   localparam int clk_mhz = 20;
   localparam int prot_erase_us = 100;
   localparam int wait_limit = prot_erase_us * clk_mhz * 2;
   localparam logic [15:0] wait_limit_c = 16'(wait_limit);

   typedef enum logic [1:0] {
      poll_data,
      poll_toggle
   } poll_mode_e;

   typedef enum logic [1:0] {
      res_ok,
      res_timeout,
      res_busy_limit
   } poll_result_e;

   typedef struct packed {
      logic [addr_w-1:0] addr;
      logic [data_w-1:0] wdata;
      logic write;
   } bus_req_s;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } strobes_s;
endpackage

// *** flash_status_poller.sv ***
// Purpose: Host-side poller that writes a command word and watches flash status.
// Assumes: One bus cycle spans bus_cycles clocks; data pins are two-way.
// Notes: Poll completes on data polling or toggle bit method, as chosen.
`timescale 1ns/10ps
`default_nettype none
module flash_status_poller (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // User orders
   input wire logic start,
   input wire logic issue_reset,
   input wire flash_status_pkg::poll_mode_e mode,
   input wire logic [flash_status_pkg::addr_w-1:0] poll_addr,
   input wire logic [flash_status_pkg::data_w-1:0] expect_data,
   output logic busy,
   output logic done,
   output flash_status_pkg::poll_result_e result,
   output logic [flash_status_pkg::data_w-1:0] final_data,
   output logic erase_suspended_sector,
   // Flash pins
   output logic [flash_status_pkg::addr_w-1:0] flash_addr,
   output flash_status_pkg::strobes_s flash_strobes,
   output logic [flash_status_pkg::data_w-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [flash_status_pkg::data_w-1:0] flash_dq_in,
   input wire logic ready_busy_out
);
   typedef enum logic [2:0] {
      st_idle,
      st_read1,
      st_read2,
      st_recheck,
      st_final,
      st_reset
   } state_e;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [flash_status_pkg::data_w-1:0] dq_s1_reg, dq_s2_reg;
   logic rb_s1_reg, rb_s2_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dq_s1_reg <= '0;
         dq_s2_reg <= '0;
         rb_s1_reg <= 1'b1;
         rb_s2_reg <= 1'b1;
      end else begin
         dq_s1_reg <= flash_dq_in;
         dq_s2_reg <= dq_s1_reg;
         rb_s1_reg <= ready_busy_out;
         rb_s2_reg <= rb_s1_reg;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   state_e state_reg, state_next;
   logic [3:0] cyc_reg, cyc_next;
   logic [15:0] wait_reg, wait_next;
   logic [flash_status_pkg::data_w-1:0] first_reg, first_next;
   logic [flash_status_pkg::data_w-1:0] fin_reg, fin_next;
   logic busy_reg, busy_next, done_reg, done_next, susp_reg, susp_next, to_seen_reg, to_seen_next;
   flash_status_pkg::poll_result_e res_reg, res_next;
   flash_status_pkg::strobes_s stb_reg, stb_next;
   logic oe_reg, oe_next;
   logic [flash_status_pkg::data_w-1:0] dqo_reg, dqo_next;
   logic [flash_status_pkg::addr_w-1:0] addr_reg, addr_next;
   logic cyc_end, is_read, settled, toggling, flipped;

   always_comb begin
      cyc_end = (cyc_reg == flash_status_pkg::bus_cycles - 4'h1);
      is_read = (state_reg != st_idle) && (state_reg != st_reset);
      toggling = (dq_s2_reg[flash_status_pkg::toggle1_bit] !=
         first_reg[flash_status_pkg::toggle1_bit]);
      settled = (dq_s2_reg[flash_status_pkg::poll_bit] == expect_data[flash_status_pkg::poll_bit]);
      flipped = (mode == flash_status_pkg::poll_data) ? settled : !toggling;
      state_next = state_reg;
      cyc_next = cyc_reg;
      wait_next = wait_reg;
      first_next = first_reg;
      fin_next = fin_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      susp_next = susp_reg;
      to_seen_next = to_seen_reg;
      res_next = res_reg;
      stb_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      oe_next = 1'b0;
      dqo_next = dqo_reg;
      addr_next = addr_reg;
      if (state_reg != st_idle) begin
         cyc_next = cyc_end ? 4'h0 : cyc_reg + 4'h1;
         // Strobe low for all but the last clock so data is sampled before release
         if (!cyc_end) begin
            stb_next.ce_n = 1'b0;
            stb_next.oe_n = !is_read;
            stb_next.we_n = is_read;
            oe_next = !is_read;
         end
      end
      case (state_reg)
         st_idle: begin
            cyc_next = 4'h0;
            if (issue_reset) begin
               state_next = st_reset;
               busy_next = 1'b1;
               addr_next = '0;
               dqo_next = {8'h00, flash_status_pkg::reset_cmd};
            end else if (start) begin
               addr_next = poll_addr;
               state_next = st_read1;
               busy_next = 1'b1;
               wait_next = '0;
               to_seen_next = 1'b0;
            end
         end
         st_reset: if (cyc_end) begin
            state_next = st_idle;
            busy_next = 1'b0;
            done_next = 1'b1;
            res_next = flash_status_pkg::res_ok;
         end
         st_read1: if (cyc_end) begin
            first_next = dq_s2_reg;
            state_next = st_read2;
         end
         st_read2: if (cyc_end) begin
            wait_next = wait_reg + 16'h1;
            susp_next = !toggling && (dq_s2_reg[flash_status_pkg::toggle2_bit] !=
               first_reg[flash_status_pkg::toggle2_bit]);
            if (flipped) begin
               state_next = st_final;
            end else if (dq_s2_reg[flash_status_pkg::timeout_bit]) begin
               // Recheck after timeout
               // Recheck against the latest read; two reads back the toggle looks settled
               to_seen_next = 1'b1;
               first_next = dq_s2_reg;
               state_next = st_recheck;
            end else if (wait_reg == flash_status_pkg::wait_limit_c) begin
               state_next = st_idle;
               busy_next = 1'b0;
               done_next = 1'b1;
               res_next = flash_status_pkg::res_busy_limit;
            end else begin
               first_next = dq_s2_reg;
            end
         end
         st_recheck: if (cyc_end) begin
            if (flipped) begin
               state_next = st_final;
            end else begin
               state_next = st_idle;
               busy_next = 1'b0;
               done_next = 1'b1;
               res_next = flash_status_pkg::res_timeout;
            end
         end
         st_final: if (cyc_end) begin
            fin_next = dq_s2_reg;
            state_next = st_idle;
            busy_next = 1'b0;
            done_next = 1'b1;
            res_next = flash_status_pkg::res_ok;
         end
         default: state_next = st_idle;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= st_idle;
         cyc_reg <= 4'h0;
         wait_reg <= '0;
         first_reg <= '0;
         fin_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         susp_reg <= 1'b0;
         to_seen_reg <= 1'b0;
         res_reg <= flash_status_pkg::res_ok;
         stb_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
         oe_reg <= 1'b0;
         dqo_reg <= '0;
         addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         cyc_reg <= cyc_next;
         wait_reg <= wait_next;
         first_reg <= first_next;
         fin_reg <= fin_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         susp_reg <= susp_next;
         to_seen_reg <= to_seen_next;
         res_reg <= res_next;
         stb_reg <= stb_next;
         oe_reg <= oe_next;
         dqo_reg <= dqo_next;
         addr_reg <= addr_next;
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;
   assign result = res_reg;
   assign final_data = fin_reg;
   assign erase_suspended_sector = susp_reg;
   assign flash_addr = addr_reg;
   assign flash_strobes = stb_reg;
   assign flash_dq_out = dqo_reg;
   assign flash_dq_oe = oe_reg;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the flash status poller.
// Assumes: 50 ns clock, inputs moved on falling edges.
// Notes: Busy limit run dominates run time.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam flash_status_pkg::poll_mode_e dm = flash_status_pkg::poll_data;
   localparam flash_status_pkg::poll_mode_e tm = flash_status_pkg::poll_toggle;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic start = 1'b0;
   logic issue_reset = 1'b0;
   logic load = 1'b0;
   logic to = 1'b0;
   logic [1:0] op = '0;
   logic [31:0] n = '0;
   flash_status_pkg::poll_mode_e mode = dm;
   logic [17:0] poll_addr = 18'h00123;
   logic [15:0] expect_data = '0;
   logic busy, done, sus, oe, rdy;
   flash_status_pkg::poll_result_e result;
   flash_status_pkg::strobes_s strobes;
   logic [15:0] final_data, dq_out, dq_in;
   logic [17:0] faddr;
   int fails = 0;
   int checks_done = 0;
   flash_status_poller u_flash_status_poller (.clk(clk), .resetn(resetn), .start(start),
      .issue_reset(issue_reset), .mode(mode), .poll_addr(poll_addr), .expect_data(expect_data),
      .busy(busy), .done(done), .result(result), .final_data(final_data),
      .erase_suspended_sector(sus), .flash_addr(faddr), .flash_strobes(strobes),
      .flash_dq_out(dq_out), .flash_dq_oe(oe), .flash_dq_in(dq_in), .ready_busy_out(rdy));
   flash_dev_model u_flash_dev_model (.strobes(strobes), .dq_out(dq_out), .dq_in(dq_in),
      .rdy(rdy), .load(load), .op(op), .n(n), .to(to), .pd(expect_data));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 60000 && done !== 1'b1; i++) @(negedge clk);
      if (done !== 1'b1) fails++;
      @(negedge clk);
   endtask
   task automatic send_reset();
      issue_reset = 1'b1;
      @(negedge clk);
      issue_reset = 1'b0;
      wait_done();
      check({15'h0, rdy}, 16'h0001);
      check(16'(result), 16'(flash_status_pkg::res_ok));
   endtask
   task automatic run(input logic [1:0] o, input logic [31:0] k, input logic t,
      input flash_status_pkg::poll_mode_e m, input flash_status_pkg::poll_result_e r,
      input logic [15:0] d);
      op = o;
      n = k;
      to = t;
      mode = m;
      expect_data = d;
      load = 1'b1;
      @(posedge clk);
      check({15'h0, rdy}, {15'h0, o == 2'd3});
      @(negedge clk);
      load = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wait_done();
      check(16'(result), 16'(r));
      if (r == flash_status_pkg::res_ok) begin
         check(final_data, d);
         check({15'h0, sus}, {15'h0, o == 2'd3});
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      run(2'd1, 5, 1'b0, dm, flash_status_pkg::res_ok, 16'h00a5);
      run(2'd1, 1, 1'b0, dm, flash_status_pkg::res_ok, 16'h1234);
      run(2'd2, 6, 1'b0, tm, flash_status_pkg::res_ok, 16'hffff);
      run(2'd3, 2, 1'b0, tm, flash_status_pkg::res_ok, 16'h5a3c);
      run(2'd1, 30, 1'b1, dm, flash_status_pkg::res_timeout, 16'h0080);
      send_reset();
      run(2'd2, 30, 1'b1, tm, flash_status_pkg::res_timeout, 16'hffff);
      send_reset();
      run(2'd2, 32'h000f0000, 1'b0, tm, flash_status_pkg::res_busy_limit, 16'hffff);
      send_reset();
      final_report();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
